// ===== core/crg_pkg.sv
// constants for the clock and reset generator
package crg_pkg;
  // register bus widths
  localparam int CRG_AW = 4;
  localparam int CRG_DW = 8;
  // register offsets
  localparam logic [3:0] CRG_SYNTH = 4'h0;
  localparam logic [3:0] CRG_REFDIV = 4'h1;
  localparam logic [3:0] CRG_VCO_POST_DIVIDER = 4'h2;
  localparam logic [3:0] CRG_FLAGS = 4'h3;
  localparam logic [3:0] CRG_IRQEN = 4'h4;
  localparam logic [3:0] CRG_SYSTEM_CLOCK_SELECT = 4'h5;
  localparam logic [3:0] CRG_LOOPCTL = 4'h6;
  localparam logic [3:0] CRG_TICK = 4'h7;
  localparam logic [3:0] CRG_WDCTL = 4'h8;
  localparam logic [3:0] CRG_WDSVC = 4'h9;
  localparam logic [3:0] CRG_WAKE = 4'hA;
  // field positions
  localparam int CRG_FLD_HI = 7; // gain, filter range
  localparam int CRG_FLD_LO = 6;
  localparam int CRG_MOD_HI = 5;
  localparam int CRG_MOD_LO = 4;
  localparam int CRG_LOOP_EN = 6;
  localparam int CRG_TICKIF = 7;
  localparam int CRG_LOCKIF = 4;
  localparam int CRG_LOCK = 3;
  localparam int CRG_ILLEGAL_ADDRESS_RESET_FLAG = 2;
  localparam int CRG_IRQ_RSV = 6;
  localparam int CRG_LOOPSEL = 7;
  localparam int CRG_OSC_ON = 6;
  localparam int CRG_LATCHED_OSCILLATOR_CONFIG = 5;
  localparam int CRG_DECIMAL = 7;
  localparam int CRG_WD_WIN = 7;
  // reset values, masks and watchdog codes
  localparam logic [7:0] CRG_ZERO = 8'h00;
  localparam logic [7:0] CRG_IRQEN_MASK = 8'hBF;
  localparam logic [7:0] CRG_LOOPCTL_MASK = 8'h70;
  localparam logic [7:0] CRG_WDCTL_MASK = 8'h87;
  localparam logic [7:0] CRG_NV_ERASED = 8'hFF;
  localparam logic [7:0] CRG_WD_ARM = 8'h55;
  localparam logic [7:0] CRG_WD_KICK = 8'hAA;
  // prescaler shapes
  localparam int CRG_TICK_W = 23;
  localparam int CRG_BIN_BASE = 8;
  localparam logic [22:0] CRG_DEC_STEP [8] = '{
    23'h000000, 23'h0003E8, 23'h0007D0, 23'h001388,
    23'h002710, 23'h004E20, 23'h00C350, 23'h078000};
  localparam int CRG_WD_W = 21;
  localparam int CRG_WD_BASE = 13;
  localparam int CRG_WAKE_W = 17;
  // rc oscillator tick period, 0.2 ms
  localparam int CRG_RC_TICK_US = 200;
  // stop mode states
  typedef enum logic [1:0] {
    CRG_RUN = 2'b00,
    CRG_STOP = 2'b01,
    CRG_FAST = 2'b10
  } crg_mode_e;
endpackage

// ===== core/crg_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module crg_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule // crg_sync

// ===== core/crg_divider.sv
// reloadable down counter giving one pulse per ratio steps
`timescale 1ns/10ps
module crg_divider #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  input wire logic step_in,
  input wire logic [W-1:0] ratio_m1_in,
  // result
  output logic pulse_out
);
  logic [W-1:0] count;

  // new ratio takes effect at the next reload, avoiding short periods
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      count <= '0;
      pulse_out <= 1'b0;
    end else if (step_in) begin
      pulse_out <= (count == '0);
      count <= (count == '0) ? ratio_m1_in : count - 1'b1;
    end else begin
      pulse_out <= 1'b0;
    end
  end
endmodule // crg_divider

// ===== core/crg_top.sv
// clock and reset generator register file, dividers, watchdog, wake
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module crg_top
  import crg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [CRG_AW-1:0] addr_in,
  input wire logic [CRG_DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [CRG_DW-1:0] rdata_out,
  // pins and system events
  input wire logic lock_in,
  input wire logic wake_pin_in,
  input wire logic rc_osc_in,
  input wire logic osc_config_in,
  input wire logic [7:0] wd_nv_in,
  input wire logic illegal_addr_in,
  input wire logic stop_req_in,
  // loop settings
  output logic [1:0] vco_gain_out,
  output logic [1:0] filter_range_out,
  output logic [5:0] multiplier_out,
  output logic [5:0] ref_div_out,
  output logic loop_enable_out,
  output logic mod_en_out,
  output logic [1:0] mod_amp_out,
  // clocks, ticks, resets and power
  output logic loop_clk_out,
  output logic tick_out,
  output logic wdog_reset_out,
  output logic osc_enable_out,
  output logic clk_from_loop_out,
  output logic cpu_run_out
);
  logic [7:0] synth, refdiv, vco_post_divider, flags, irqen, system_clock_select;
  logic [7:0] loopctl, tickctl, wdctl, wakectl;
  logic [CRG_DW-1:0] next_rdata;
  logic [2:0] pins;
  logic locked, wake_pin, rc_lvl, rc_prev, rc_edge, lock_prev;
  logic latched_oscillator_config, boot;
  logic post_pulse, tick_pulse, rc_wake;
  logic [CRG_TICK_W-1:0] next_tick_ratio;
  logic [CRG_WAKE_W-1:0] next_wake_ratio;
  logic [2:0] wd_rate;
  logic wd_window, wd_armed;
  logic [CRG_WD_W-1:0] wd_cnt, wd_limit;
  logic wr_svc;
  crg_mode_e mode;

  // pin levels cross into the clock domain
  crg_sync #(.W(3)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({lock_in, wake_pin_in, rc_osc_in}),
    .q_out(pins)
  );
  assign locked = pins[2];
  assign wake_pin = pins[1];
  assign rc_lvl = pins[0];
  assign rc_edge = rc_lvl && !rc_prev;
  assign wr_svc = wr_in && (addr_in == CRG_WDSVC);

  // plain read-write loop, tick and wake setup registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      synth <= CRG_ZERO;
      refdiv <= CRG_ZERO;
      vco_post_divider <= CRG_ZERO;
      tickctl <= CRG_ZERO;
      wakectl <= CRG_ZERO;
    end else if (wr_in) begin
      case (addr_in)
        CRG_SYNTH: synth <= wdata_in;
        CRG_REFDIV: refdiv <= wdata_in;
        CRG_VCO_POST_DIVIDER: vco_post_divider <= wdata_in;
        CRG_TICK: tickctl <= wdata_in;
        CRG_WAKE: wakectl <= wdata_in;
        default: ;
      endcase
    end
  end

  // loop control keeps only enable and modulation bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      loopctl <= CRG_ZERO;
      irqen <= CRG_ZERO;
    end else if (wr_in && addr_in == CRG_LOOPCTL) begin
      loopctl <= wdata_in & CRG_LOOPCTL_MASK;
    end else if (wr_in && addr_in == CRG_IRQEN) begin
      irqen <= wdata_in & CRG_IRQEN_MASK;
    end
  end

  // setting outputs; only the modulation pair is registered so it follows its code
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mod_en_out <= 1'b0;
      mod_amp_out <= 2'b00;
    end else begin
      mod_en_out <= |loopctl[CRG_MOD_HI:CRG_MOD_LO];
      mod_amp_out <= loopctl[CRG_MOD_HI:CRG_MOD_LO];
    end
  end
  assign vco_gain_out = synth[CRG_FLD_HI:CRG_FLD_LO];
  assign filter_range_out = refdiv[CRG_FLD_HI:CRG_FLD_LO];
  assign multiplier_out = synth[5:0];
  assign ref_div_out = refdiv[5:0];
  assign loop_enable_out = loopctl[CRG_LOOP_EN];

  // boot capture one edge after reset release; straps never in reset path
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      boot <= 1'b1;
      latched_oscillator_config <= 1'b0;
    end else if (boot) begin
      boot <= 1'b0;
      latched_oscillator_config <= osc_config_in;
    end
  end

  // clock select: bit 5 is never written
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      system_clock_select <= CRG_ZERO;
    end else if (wr_in && addr_in == CRG_SYSTEM_CLOCK_SELECT) begin
      system_clock_select[CRG_LOOPSEL] <= wdata_in[CRG_LOOPSEL];
      system_clock_select[CRG_OSC_ON] <= wdata_in[CRG_OSC_ON];
    end else if (mode != CRG_RUN) begin
      // a restart left from an earlier wake must not end the next fast wake
      system_clock_select[CRG_OSC_ON] <= 1'b0;
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags <= CRG_ZERO;
      lock_prev <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      lock_prev <= locked;
      rc_prev <= rc_lvl;
      if (wr_in && addr_in == CRG_FLAGS) begin
        flags[CRG_TICKIF] <= flags[CRG_TICKIF] & ~wdata_in[CRG_TICKIF];
        flags[CRG_LOCKIF] <= flags[CRG_LOCKIF] & ~wdata_in[CRG_LOCKIF];
        flags[CRG_ILLEGAL_ADDRESS_RESET_FLAG] <= flags[CRG_ILLEGAL_ADDRESS_RESET_FLAG] & ~wdata_in[CRG_ILLEGAL_ADDRESS_RESET_FLAG];
      end
      if (tick_pulse) begin
        flags[CRG_TICKIF] <= 1'b1;
      end
      if (locked != lock_prev) begin
        flags[CRG_LOCKIF] <= 1'b1;
      end
      if (illegal_addr_in) begin
        flags[CRG_ILLEGAL_ADDRESS_RESET_FLAG] <= 1'b1;
      end
    end
  end

  // post divider: a pulse every vco_post_divider+1 vco edges toggles the output
  crg_divider #(.W(8)) u_post (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(loopctl[CRG_LOOP_EN]),
    .step_in(1'b1),
    .ratio_m1_in(vco_post_divider),
    .pulse_out(post_pulse)
  );
  always_ff @(posedge clk_in) begin
    if (rst_in || !loopctl[CRG_LOOP_EN]) begin
      loop_clk_out <= 1'b0;
    end else if (post_pulse) begin
      loop_clk_out <= ~loop_clk_out;
    end
  end

  // tick ratio; exponent zero stops the prescaler as before
  always_comb begin
    if (tickctl[CRG_DECIMAL]) begin
      next_tick_ratio = CRG_TICK_W'((tickctl[3:0] + 5'h01)
        * CRG_DEC_STEP[tickctl[6:4]]) - 1'b1;
    end else begin
      next_tick_ratio = (CRG_TICK_W'(tickctl[3:0] + 5'h01)
        << (tickctl[6:4] + CRG_BIN_BASE)) - 1'b1;
    end
  end
  crg_divider #(.W(CRG_TICK_W)) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(|tickctl[6:4]),
    .step_in(1'b1),
    .ratio_m1_in(next_tick_ratio),
    .pulse_out(tick_pulse)
  );
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_pulse;
    end
  end

  // rc wake interval counts 0.2 ms rc ticks, only while stopped
  always_comb begin
    next_wake_ratio = (CRG_WAKE_W'(wakectl[3:0] + 5'h01)
      << (wakectl[7:4] - 4'h1)) - 1'b1;
  end
  crg_divider #(.W(CRG_WAKE_W)) u_wake (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in((|wakectl[7:4]) && mode == CRG_STOP),
    .step_in(rc_edge),
    .ratio_m1_in(next_wake_ratio),
    .pulse_out(rc_wake)
  );

  // stop mode sequencing; wake runs from the loop with the crystal off
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode <= CRG_RUN;
    end else begin
      case (mode)
        CRG_RUN: if (stop_req_in) mode <= CRG_STOP;
        CRG_STOP: if (wake_pin || rc_wake) mode <= CRG_FAST;
        CRG_FAST: begin
          if (stop_req_in) begin
            mode <= CRG_STOP;
          end else if (system_clock_select[CRG_OSC_ON]) begin
            mode <= CRG_RUN;
          end
        end
        default: mode <= CRG_RUN;
      endcase
    end
  end

  // power and clock source outputs follow the mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      osc_enable_out <= 1'b1;
      cpu_run_out <= 1'b1;
      clk_from_loop_out <= 1'b0;
    end else begin
      osc_enable_out <= (mode == CRG_RUN);
      cpu_run_out <= (mode != CRG_STOP);
      clk_from_loop_out <= (mode == CRG_FAST) ||
        (system_clock_select[CRG_LOOPSEL] && locked);
    end
  end

  // watchdog setup: from flash at boot, then writable only while off
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wd_rate <= 3'h0;
      wd_window <= 1'b0;
    end else if (boot) begin
      if (wd_nv_in == CRG_NV_ERASED) begin
        wd_rate <= 3'h0;
        wd_window <= 1'b0;
      end else begin
        wd_rate <= wd_nv_in[2:0];
        wd_window <= wd_nv_in[CRG_WD_WIN];
      end
    end else if (wr_in && addr_in == CRG_WDCTL && wd_rate == 3'h0) begin
      wd_rate <= wdata_in[2:0];
      wd_window <= wdata_in[CRG_WD_WIN];
    end
  end
  assign wdctl = {wd_window, 4'h0, wd_rate};
  assign wd_limit = CRG_WD_W'(1) << (wd_rate + CRG_WD_BASE);

  // watchdog counter; bad or early service resets like a timeout
  always_ff @(posedge clk_in) begin
    if (rst_in || wd_rate == 3'h0) begin
      wd_cnt <= '0;
      wd_armed <= 1'b0;
      wdog_reset_out <= 1'b0;
    end else begin
      wdog_reset_out <= 1'b0;
      wd_cnt <= wd_cnt + 1'b1;
      if (wd_cnt >= wd_limit - 1'b1) begin
        wdog_reset_out <= 1'b1;
        wd_cnt <= '0;
      end else if (wr_svc && wdata_in == CRG_WD_ARM) begin
        wd_armed <= 1'b1;
      end else if (wr_svc && wdata_in == CRG_WD_KICK && wd_armed &&
          (!wd_window || wd_cnt >= wd_limit - (wd_limit >> 2))) begin
        wd_armed <= 1'b0;
        wd_cnt <= '0;
      end else if (wr_svc) begin
        wdog_reset_out <= 1'b1;
        wd_armed <= 1'b0;
        wd_cnt <= '0;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (addr_in)
      CRG_SYNTH: next_rdata = synth;
      CRG_REFDIV: next_rdata = refdiv;
      CRG_VCO_POST_DIVIDER: next_rdata = vco_post_divider;
      CRG_FLAGS: next_rdata = {flags[7:4], locked, flags[2:0]};
      CRG_IRQEN: next_rdata = irqen;
      CRG_SYSTEM_CLOCK_SELECT: next_rdata = {system_clock_select[7:6], latched_oscillator_config, system_clock_select[4:0]};
      CRG_LOOPCTL: next_rdata = loopctl;
      CRG_TICK: next_rdata = tickctl;
      CRG_WDCTL: next_rdata = wdctl;
      CRG_WAKE: next_rdata = wakectl;
      default: next_rdata = CRG_ZERO;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= CRG_ZERO;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= CRG_ZERO;
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  illegal_address_reset_flag_set_a: assert property (
    illegal_addr_in |=> flags[CRG_ILLEGAL_ADDRESS_RESET_FLAG] ##1 flags[CRG_ILLEGAL_ADDRESS_RESET_FLAG])
    else $error("illegal address flag not held");
  irq_reserved_a: assert property (
    rd_in && addr_in == CRG_IRQEN |=> !rdata_out[CRG_IRQ_RSV])
    else $error("reserved enable bit reads one");
  latched_oscillator_config_hold_a: assert property (
    wr_in && addr_in == CRG_SYSTEM_CLOCK_SELECT && !boot |=> $stable(latched_oscillator_config))
    else $error("oscillator config bit changed by write");
  mod_off_a: assert property (
    loopctl[CRG_MOD_HI:CRG_MOD_LO] == 2'b00 |=> !mod_en_out)
    else $error("modulation on with code zero");
  loop_bits_a: assert property (
    rd_in && addr_in == CRG_LOOPCTL |=> (rdata_out & ~CRG_LOOPCTL_MASK) == 0)
    else $error("removed loop control bit reads one");
  wd_erased_a: assert property (
    boot && wd_nv_in == CRG_NV_ERASED |=> wd_rate == 3'h0 ##1 !wdog_reset_out)
    else $error("erased byte enabled watchdog");
  wd_load_a: assert property (
    boot && wd_nv_in != CRG_NV_ERASED |=> wd_rate == $past(wd_nv_in[2:0]))
    else $error("watchdog rate not loaded");
  fast_wake_a: assert property (
    mode == CRG_STOP && wake_pin |=> mode == CRG_FAST
      ##1 (cpu_run_out && clk_from_loop_out && !osc_enable_out))
    else $error("wake did not run from loop clock");
  tick_flag_a: assert property (
    tick_pulse |=> tick_out && flags[CRG_TICKIF])
    else $error("tick not flagged");
  post_hold_a: assert property (
    loopctl[CRG_LOOP_EN] && $stable(loopctl) && !post_pulse
      |=> $stable(loop_clk_out))
    else $error("loop clock toggled without divider pulse");
endmodule // crg_top

// ===== dv/crg_osc_model.sv
// oscillator, rc timer, strap and boot byte model for the generator
`timescale 1ns/10ps
module crg_osc_model #(
  parameter int RC_HALF_NS = 100000,
  parameter int LOCK_DLY = 20
) (
  // clock and loop state
  input wire logic clk_in,
  input wire logic loop_enable_in,
  // strap and boot byte chosen by the bench
  input wire logic strap_in,
  input wire logic [7:0] nv_byte_in,
  // modelled far side
  output logic lock_out,
  output logic rc_osc_out,
  output logic osc_config_out,
  output logic [7:0] wd_nv_out
);
  int cnt = 0;
  // rc oscillator runs free, one tick per 0.2 ms
  initial begin
    rc_osc_out = 1'b0;
    forever #(RC_HALF_NS) rc_osc_out = ~rc_osc_out;
  end
  // one settle time, no separate acquisition phase; drops at once
  always_ff @(posedge clk_in) begin
    if (!loop_enable_in) begin
      cnt <= 0;
    end else if (cnt < LOCK_DLY) begin
      cnt <= cnt + 1;
    end
  end
  // lock level, strap and boot byte seen by the device
  assign lock_out = (cnt == LOCK_DLY);
  assign osc_config_out = strap_in;
  assign wd_nv_out = nv_byte_in;
endmodule // crg_osc_model

// ===== dv/crg_top_tb.sv
// self-checking bench for the clock and reset generator
`timescale 1ns/10ps
module crg_top_tb;
  import crg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic wake_pin_in = 1'b0;
  logic illegal_addr_in = 1'b0;
  logic stop_req_in = 1'b0;
  logic [7:0] nv_byte = 8'hFF;
  logic strap = 1'b1;
  logic [7:0] rdata_out, wd_nv_in;
  logic lock_in, rc_osc_in, osc_config_in;
  logic [1:0] vco_gain_out, filter_range_out, mod_amp_out;
  logic [5:0] multiplier_out, ref_div_out;
  logic loop_enable_out, mod_en_out, loop_clk_out, tick_out;
  logic wdog_reset_out, osc_enable_out, clk_from_loop_out, cpu_run_out;
  int err_count = 0;
  int compares = 0;
  int seed = 32'h9537e428;
  int regm [16];
  int n, v, c, i;

  crg_top DUT (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .lock_in, .wake_pin_in, .rc_osc_in, .osc_config_in,
    .wd_nv_in, .illegal_addr_in, .stop_req_in, .vco_gain_out,
    .filter_range_out, .multiplier_out, .ref_div_out, .loop_enable_out,
    .mod_en_out, .mod_amp_out, .loop_clk_out, .tick_out, .wdog_reset_out,
    .osc_enable_out, .clk_from_loop_out, .cpu_run_out);
  crg_osc_model osc (.clk_in, .loop_enable_in(loop_enable_out),
    .strap_in(strap), .nv_byte_in(nv_byte), .lock_out(lock_in),
    .rc_osc_out(rc_osc_in), .osc_config_out(osc_config_in),
    .wd_nv_out(wd_nv_in));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic report_and_stop;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // writable bits per offset; read-only and unmapped bits stay clear
  function automatic int wmask(input int a);
    case (a)
      4: return 'hBF;
      5: return 'hC0;
      6: return 'h70;
      0, 1, 2, 7, 10: return 'hFF;
      default: return 0;
    endcase
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    if (a != 4'h8) begin
      regm[a] = (d & wmask(a)) | ((a == 4'h5 && strap) ? 'h20 : 0);
    end
  endtask

  // read data stand in the cycle after the strobe only
  task automatic rd(input logic [3:0] a, input string what);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, rdata_out, regm[a]);
  endtask

  // cycles from second to third event, past any period of an old ratio
  task automatic span(ref logic s, input bit tog, output int len);
    logic last;
    int k, t;
    k = 0;
    t = 0;
    last = s;
    while (k < 3 && t < 30000) begin
      @(posedge clk_in);
      #1;
      len++;
      t++;
      if (tog ? (s !== last) : (s === 1'b1 && last !== 1'b1)) begin
        k++;
        if (k == 2) len = 0;
      end
      last = s;
    end
  endtask

  task automatic wait_hi(ref logic s, output int len);
    len = 0;
    while (s !== 1'b1 && len < 40000) begin
      @(posedge clk_in);
      #1;
      len++;
    end
  endtask

  // one-cycle event: stop request, or illegal address
  task automatic pulse(input bit stop);
    @(posedge clk_in);
    if (stop) begin
      stop_req_in <= 1'b1;
    end else begin
      illegal_addr_in <= 1'b1;
    end
    @(posedge clk_in);
    stop_req_in <= 1'b0;
    illegal_addr_in <= 1'b0;
  endtask

  // boot byte only sampled after release, so registers restart here
  task automatic do_reset(input logic [7:0] nv, input logic s);
    nv_byte <= nv;
    strap <= s;
    rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (regm[k]) regm[k] = 0;
    regm[5] = s ? 'h20 : 0;
    regm[8] = (nv == 8'hFF) ? 0 : nv & 8'h87;
    repeat (2) @(posedge clk_in);
  endtask

  // hang guard, well beyond the longest sequence
  initial begin
    repeat (150000) @(posedge clk_in);
    err_count++;
    report_and_stop();
  end

  initial begin
    do_reset(8'hFF, 1'b1);
    for (c = 0; c < 12; c++) rd(c[3:0], "reset_map");
    v = $random(seed);
    wr(0, v[7:0]);
    wr(1, v[15:8]);
    rd(0, "synth");
    chk("gain", vco_gain_out, v[7:6]);
    chk("range", filter_range_out, v[15:14]);
    chk("mult", multiplier_out, v[5:0]);
    chk("ref_div", ref_div_out, v[13:8]);
    for (c = 0; c < 4; c++) begin
      wr(6, 8'h8F | (c << 4));
      rd(6, "loopctl");
      chk("mod_en", mod_en_out, c != 0);
      chk("mod_amp", mod_amp_out, c[1:0]);
    end
    wr(4, 8'hFF);
    rd(4, "irqen");
    wr(5, 8'h3F);
    rd(5, "system_clock_select");
    pulse(1'b0);
    regm[3] = 'h04;
    rd(3, "flags");
    wr(3, 8'h04);
    rd(3, "flags_clr");
    v = $random(seed) & 7;
    wr(2, v[7:0]);
    wr(6, 8'h40);
    span(loop_clk_out, 1'b1, n);
    chk("post_div", n, v + 1);
    chk("loop_en", loop_enable_out, 1'b1);
    repeat (30) @(posedge clk_in);
    wr(5, 8'h80);
    repeat (2) @(posedge clk_in);
    #1;
    chk("loop_sel", clk_from_loop_out, 1'b1);
    for (i = 0; i < 4; i++) begin
      c = i == 0 ? 'h10 : i == 1 ? 'h11 : i == 2 ? 'h90 : 'h92;
      wr(7, c[7:0]);
      span(tick_out, 1'b0, n);
      v = c[7] ? ((c & 15) + 1) * CRG_DEC_STEP[(c >> 4) & 7]
               : ((c & 15) + 1) << (((c >> 4) & 7) + 8);
      chk("tick_span", n, v);
    end
    chk("dec_top", 16 * CRG_DEC_STEP[7], 15 * (16 << 15));
    pulse(1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    chk("stopped", {cpu_run_out, osc_enable_out}, 2'b00);
    wake_pin_in <= 1'b1;
    wait_hi(cpu_run_out, n);
    wake_pin_in <= 1'b0;
    chk("wake_time", n, 4);
    chk("fast_wake", {clk_from_loop_out, osc_enable_out}, 2'b10);
    wr(5, 8'h40);
    repeat (3) @(posedge clk_in);
    #1;
    chk("restart", osc_enable_out, 1'b1);
    wr(10, 8'h10);
    pulse(1'b1);
    repeat (3) @(posedge clk_in);
    wait_hi(cpu_run_out, n);
    chk("rc_wake", n < 8100, 1'b1);
    chk("rc_fast", osc_enable_out, 1'b0);
    do_reset(8'h01, 1'b0);
    rd(5, "latched_oscillator_config_boot");
    rd(8, "wd_boot");
    wait_hi(wdog_reset_out, n);
    chk("wd_span", n > 16370 && n < 16400, 1'b1);
    wr(9, CRG_WD_ARM);
    wr(9, CRG_WD_KICK);
    #1;
    chk("wd_kick", wdog_reset_out, 1'b0);
    wr(9, 8'h12);
    #1;
    chk("wd_bad", wdog_reset_out, 1'b1);
    report_and_stop();
  end
endmodule // crg_top_tb
